//--- common/sps_pkg.sv
package sps_pkg;
   // ==========================================
   // Clock and timing
   localparam int  CLK_HZ        = 125_000_000;
   localparam real BASE_STEP_HZ  = 7.8125;
   localparam int  PHASE_W       = 10;
   localparam int  TICK_HZ       = int'(BASE_STEP_HZ * (2.0 ** PHASE_W));
   localparam int  TICK_CYCLES   = CLK_HZ / TICK_HZ;
   localparam int  MS_PER_S      = 1000;
   localparam int  MS_CYCLES     = CLK_HZ / MS_PER_S;
   localparam int  QUARTER_CYCLES = 78;
   // ==========================================
   // Link addressing
   localparam logic [6:0] DEV_ADDR  = 7'h59;
   localparam logic       DIR_WRITE = 1'b0;
   localparam logic       DIR_READ  = 1'b1;
   // ==========================================
   // Device map
   localparam logic [7:0] REG_GO    = 8'h02;
   localparam logic [7:0] REG_SEQ0  = 8'h03;
   localparam int         SEQ_LEN   = 8;
   localparam logic [7:0] REG_PAGE  = 8'hFF;
   localparam logic [7:0] PAGE_CTRL = 8'h00;
   localparam logic [7:0] PAGE_MEM  = 8'h01;
   localparam int         GO_BIT    = 0;
   localparam int         MODE_BIT  = 7;
   localparam logic [7:0] HDR_FIRST = 8'h01;
   localparam logic [7:0] HDR_SIZE  = 8'h05;
   localparam logic [7:0] OFS_STOP  = 8'h03;
   localparam logic [7:0] OFS_REP   = 8'h04;
   // ==========================================
   // Synthesis scaling
   localparam int AMP_DIV       = 255;
   localparam int SINE_PEAK     = 127;
   localparam int RAMP_SHORT_MS = 32;
   localparam int RAMP_LONG_MS  = 256;
   localparam int RAMP_SHORT_N  = 8;
   // ==========================================
   // Controller registers
   localparam logic [2:0] H_REG_PTR   = 3'h0;
   localparam logic [2:0] H_REG_WDATA = 3'h1;
   localparam logic [2:0] H_REG_CTRL  = 3'h2;
   localparam logic [2:0] H_REG_STAT  = 3'h3;
   localparam logic [2:0] H_REG_RDATA = 3'h4;
   localparam int H_CTRL_WR   = 0;
   localparam int H_CTRL_RD   = 1;
   localparam int H_STAT_BUSY = 0;
   localparam int H_STAT_NACK = 1;
endpackage

//--- common/sps_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sps_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;
   // Open-drain data line with pull-up
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

//--- design/sps_device.sv
// Contract
// R1: Amplitude byte scales sinusoid, zero silences
// R2: Peak equals amplitude over 255 times full
// R3: Frequency is 7.8125 Hz times frequency byte
// R4: Host never programs frequency byte zero
// R5: Play whole periods, start and end zero
// R6: Duration follows cycles over base frequency
// R7: Envelope upper nibble up, lower down
// R8: Ramp-up inside duration, ramp-down appended
// R9: Host keeps ramp-up shorter than duration
// R10: Nibble decodes to 32 or 256 ms steps
// R11: Ramp time scales with target amplitude
// R12: Host stores parameters before starting
// R13: All control only over two-wire slave
// R14: Slave answers fixed seven-bit address
// R15: Repeat count zero loops until stopped
// R16: Page register at 0xFF selects page
// R17: Go bit starts, self-clears, cancels playback
// R18: Header mode bit selects synthesis or direct
// R19: Play sequence entries until zero or eight
// R20: Parameters fetched amplitude, frequency, cycles, envelope
// R21: Output held zero while not playing
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sps_device #(
   parameter int TICK_CYCLES = sps_pkg::TICK_CYCLES,
   parameter int MS_CYCLES   = sps_pkg::MS_CYCLES
)(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset_n,
   // Two-wire link
   sps_if.dev                      link,
   // Synthesizer output
   output logic signed [7:0]       sample,
   output logic                    playing
);
   typedef enum {I_IDLE, I_RX, I_RX_ACK, I_TX, I_TX_ACK} sps_link_type;
   typedef enum {Q_IDLE, Q_ID, Q_HDR, Q_PAR, Q_PLAY, Q_FALL, Q_DIRECT, Q_NEXT} sps_seq_type;

   // ==========================================
   // Functions
   function automatic int ramp_cycles(input logic [3:0] n, input int unit);
      int ms;
      int c;
      ms = (int'(n) <= sps_pkg::RAMP_SHORT_N) ? int'(n) * sps_pkg::RAMP_SHORT_MS
         : (int'(n) - 7) * sps_pkg::RAMP_LONG_MS; // R10
      c  = ms * unit / sps_pkg::AMP_DIV; // R11
      return (c < 1) ? 1 : c;
   endfunction

   function automatic logic signed [7:0] sine_at(input logic [9:0] ph, input logic [7:0] lvl);
      logic [8:0]  p;
      logic [17:0] prod;
      logic [6:0]  mag;
      logic [6:0]  m;
      p    = ph[8:0];
      prod = 18'(p) * 18'(10'd512 - 10'(p));
      mag  = 7'((25'(prod) * 25'(sps_pkg::SINE_PEAK)) >> 16);
      m    = 7'((15'(mag) * 15'(lvl)) / 15'(sps_pkg::AMP_DIV)); // R1 R2
      return ph[9] ? -$signed({1'b0, m}) : $signed({1'b0, m});
   endfunction

   // ==========================================
   // Storage
   logic [7:0]   mem [256];
   logic [7:0]   seq [sps_pkg::SEQ_LEN];
   logic [7:0]   page;
   logic         go;

   // ==========================================
   // Link slave
   sps_link_type i_st;
   logic         scl_q;
   logic         sda_q;
   logic [3:0]   bit_cnt;
   logic [7:0]   shreg;
   logic [7:0]   txsh;
   logic [7:0]   ptr;
   logic         first;
   logic         need_ptr;
   logic         first_data;
   logic         is_read;
   logic         acked;
   logic         sda_drive;

   wire scl_rise   = link.scl & ~scl_q;
   wire scl_fall   = ~link.scl & scl_q;
   wire start_cond = link.scl & scl_q & sda_q & ~link.sda;
   wire stop_cond  = link.scl & scl_q & ~sda_q & link.sda;
   wire byte_done  = (i_st == I_RX) && scl_fall && (bit_cnt == 4'h8);
   wire addr_hit   = (shreg[7:1] == sps_pkg::DEV_ADDR); // R14
   wire wr_en      = byte_done && !first && !need_ptr && !is_read; // R13
   wire page_wr    = wr_en && first_data && (ptr == sps_pkg::REG_PAGE); // R16
   wire mem_sel    = (page == sps_pkg::PAGE_MEM);
   wire ctrl_wr    = wr_en && !page_wr && !mem_sel;
   wire mem_wr     = wr_en && !page_wr && mem_sel;
   wire go_wr      = ctrl_wr && (ptr == sps_pkg::REG_GO);
   wire [7:0] seq_ofs = ptr - sps_pkg::REG_SEQ0;
   wire seq_hit    = (ptr >= sps_pkg::REG_SEQ0) && (int'(seq_ofs) < sps_pkg::SEQ_LEN);
   wire [7:0] ctrl_rd = (ptr == sps_pkg::REG_GO) ? {7'h00, go}
                      : seq_hit ? seq[seq_ofs[2:0]] : 8'h00;
   wire [7:0] rd_byte = (ptr == sps_pkg::REG_PAGE) ? page : mem_sel ? mem[ptr] : ctrl_rd;

   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = sda_drive;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= link.scl;
         sda_q <= link.sda;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         i_st       <= I_IDLE;
         bit_cnt    <= 4'h0;
         shreg      <= 8'h00;
         txsh       <= 8'h00;
         ptr        <= 8'h00;
         first      <= 1'b0;
         need_ptr   <= 1'b0;
         first_data <= 1'b0;
         is_read    <= 1'b0;
         acked      <= 1'b0;
         sda_drive  <= 1'b0;
      end
      else if (start_cond)
      begin
         i_st      <= I_RX;
         bit_cnt   <= 4'h0;
         first     <= 1'b1;
         sda_drive <= 1'b0;
      end
      else if (stop_cond)
      begin
         i_st      <= I_IDLE;
         sda_drive <= 1'b0;
      end
      else
      begin
         case (i_st)
            I_RX:
            begin
               if (scl_rise)
               begin
                  shreg   <= {shreg[6:0], link.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (byte_done)
               begin
                  bit_cnt <= 4'h0;
                  if (first)
                  begin
                     first     <= 1'b0;
                     is_read   <= shreg[0];
                     need_ptr  <= (shreg[0] == sps_pkg::DIR_WRITE);
                     sda_drive <= addr_hit;
                     i_st      <= addr_hit ? I_RX_ACK : I_IDLE; // R14
                  end
                  else
                  begin
                     sda_drive  <= 1'b1;
                     i_st       <= I_RX_ACK;
                     need_ptr   <= 1'b0;
                     first_data <= need_ptr;
                     ptr        <= need_ptr ? shreg : ptr + 8'h01;
                  end
               end
            end
            I_RX_ACK, I_TX_ACK:
            begin
               if (scl_rise)
                  acked <= ~link.sda;
               if (scl_fall)
               begin
                  if (is_read && (i_st == I_RX_ACK || acked))
                  begin
                     txsh      <= rd_byte;
                     ptr       <= ptr + 8'h01;
                     sda_drive <= ~rd_byte[7];
                     i_st      <= I_TX;
                  end
                  else
                  begin
                     sda_drive <= 1'b0;
                     i_st      <= is_read ? I_IDLE : I_RX;
                  end
               end
            end
            I_TX:
            begin
               if (scl_rise)
                  bit_cnt <= bit_cnt + 4'h1;
               if (scl_fall)
               begin
                  if (bit_cnt == 4'h8)
                  begin
                     sda_drive <= 1'b0;
                     bit_cnt   <= 4'h0;
                     i_st      <= I_TX_ACK;
                  end
                  else
                  begin
                     txsh      <= {txsh[6:0], 1'b0};
                     sda_drive <= ~txsh[6];
                  end
               end
            end
            default:
               sda_drive <= 1'b0;
         endcase
      end
   end

   // ==========================================
   // Register writes
   sps_seq_type  q_st;
   wire seq_done;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         page <= sps_pkg::PAGE_CTRL;
         go   <= 1'b0;
         for (int i = 0; i < sps_pkg::SEQ_LEN; i++)
            seq[i] <= 8'h00;
      end
      else
      begin
         if (page_wr)
            page <= shreg; // R16
         if (ctrl_wr && seq_hit)
            seq[seq_ofs[2:0]] <= shreg;
         if (go_wr)
            go <= shreg[sps_pkg::GO_BIT]; // R17
         else if (seq_done)
            go <= 1'b0; // R17
      end
   end

   always_ff @(posedge clk)
   begin
      if (mem_wr)
         mem[ptr] <= shreg;
   end

   // ==========================================
   // Sequencer and synthesis
   logic [3:0]   idx;
   logic         mode;
   logic [7:0]   start_a;
   logic [7:0]   stop_a;
   logic [7:0]   rep;
   logic [7:0]   rep_left;
   logic [7:0]   addr_cur;
   logic [7:0]   amp;
   logic [7:0]   freq;
   logic [7:0]   cyc;
   logic [7:0]   cyc_cnt;
   logic [7:0]   env;
   logic [7:0]   level;
   logic [9:0]   phase;
   logic [31:0]  step_cnt;
   logic [31:0]  tick_cnt;

   wire tick       = (tick_cnt == 32'(TICK_CYCLES - 1));
   wire [7:0] cur_id = seq[idx[2:0]];
   wire [7:0] hb     = 8'(sps_pkg::HDR_FIRST + (cur_id - 8'h01) * sps_pkg::HDR_SIZE);
   wire [10:0] ph_sum = 11'(phase) + 11'(freq); // R3
   wire [3:0] up_nib = env[7:4]; // R7
   wire [3:0] dn_nib = env[3:0]; // R7
   wire [31:0] step_lim = 32'(ramp_cycles((q_st == Q_FALL) ? dn_nib : up_nib, MS_CYCLES));
   wire step_hit   = (step_cnt >= step_lim - 32'h1);
   wire cyc_end    = (cyc_cnt == cyc); // R5 R6
   assign seq_done = (q_st == Q_ID) && ((int'(idx) == sps_pkg::SEQ_LEN) || cur_id == 8'h00); // R19
   assign playing  = (q_st != Q_IDLE);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_cnt <= 32'h0;
      else
         tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q_st <= Q_IDLE;
         idx <= 4'h0;
         mode <= 1'b0;
         start_a <= 8'h00;
         stop_a <= 8'h00;
         rep <= 8'h00;
         rep_left <= 8'h00;
         addr_cur <= 8'h00;
         amp <= 8'h00;
         freq <= 8'h00;
         cyc <= 8'h00;
         env <= 8'h00;
         cyc_cnt <= 8'h00;
         level <= 8'h00;
         phase <= 10'h000;
         step_cnt <= 32'h0;
         sample <= 8'sh00;
      end
      else if (!go)
      begin
         q_st   <= Q_IDLE; // R17
         level  <= 8'h00;
         sample <= 8'sh00; // R21
      end
      else
      begin
         case (q_st)
            Q_IDLE:
            begin
               idx  <= 4'h0;
               q_st <= Q_ID; // R19
            end
            Q_ID:
               q_st <= seq_done ? Q_IDLE : Q_HDR;
            Q_HDR:
            begin
               mode     <= mem[hb][sps_pkg::MODE_BIT]; // R18
               start_a  <= mem[hb + 8'h01];
               stop_a   <= mem[hb + sps_pkg::OFS_STOP];
               rep      <= mem[hb + sps_pkg::OFS_REP];
               rep_left <= mem[hb + sps_pkg::OFS_REP];
               q_st     <= Q_PAR;
            end
            Q_PAR:
            begin
               amp      <= mem[start_a]; // R20
               freq     <= mem[start_a + 8'h01];
               cyc      <= mem[start_a + 8'h02];
               env      <= mem[start_a + 8'h03];
               level    <= (mem[start_a + 8'h03][7:4] == 4'h0) ? mem[start_a] : 8'h00;
               phase    <= 10'h000; // R5
               cyc_cnt  <= 8'h00;
               step_cnt <= 32'h0;
               addr_cur <= start_a;
               q_st     <= mode ? Q_PLAY : Q_DIRECT; // R18
            end
            Q_PLAY, Q_FALL:
            begin
               if (tick)
               begin
                  phase  <= ph_sum[9:0];
                  sample <= sine_at(ph_sum[9:0], level);
                  if (ph_sum[10] && q_st == Q_PLAY)
                     cyc_cnt <= cyc_cnt + 8'h01;
               end
               step_cnt <= step_hit ? 32'h0 : step_cnt + 32'h1;
               if (q_st == Q_PLAY)
               begin
                  if (up_nib != 4'h0 && level < amp && step_hit)
                     level <= level + 8'h01; // R8 R11
                  if (cyc_end)
                  begin
                     step_cnt <= 32'h0;
                     q_st     <= (dn_nib != 4'h0 && level != 8'h00) ? Q_FALL : Q_NEXT; // R8
                  end
               end
               else if (level == 8'h00)
                  q_st <= Q_NEXT;
               else if (step_hit)
                  level <= level - 8'h01; // R8 R11
            end
            Q_DIRECT:
            begin
               if (tick)
               begin
                  sample   <= $signed(mem[addr_cur]);
                  addr_cur <= addr_cur + 8'h01;
                  if (addr_cur == stop_a)
                     q_st <= Q_NEXT;
               end
            end
            Q_NEXT:
            begin
               sample <= 8'sh00; // R21
               if (rep == 8'h00)
                  q_st <= Q_PAR; // R15
               else if (rep_left > 8'h01)
               begin
                  rep_left <= rep_left - 8'h01;
                  q_st     <= Q_PAR;
               end
               else
               begin
                  idx  <= idx + 4'h1;
                  q_st <= Q_ID;
               end
            end
            default:
               q_st <= Q_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- design/sps_host.sv
`timescale 1ns/1ps
`default_nettype none
module sps_host #(
   parameter int QUARTER_CYCLES = sps_pkg::QUARTER_CYCLES
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Two-wire link
   sps_if.host              link,
   // Register port
   input  wire logic [2:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata
);
   typedef enum {H_IDLE, H_START, H_BYTE, H_STOP} sps_hstep_type;

   function automatic sps_hstep_type kind_of(input logic [2:0] s, input logic r);
      if (s == 3'h0 || (r && s == 3'h3))
         return H_START;
      if (s == (r ? 3'h6 : 3'h4))
         return H_STOP;
      return H_BYTE;
   endfunction

   sps_hstep_type h_st;
   logic [7:0]   ptr_r;
   logic [7:0]   wdata_r;
   logic [7:0]   rxsh;
   logic [7:0]   rdata_r;
   logic         busy;
   logic         nack;
   logic         is_rd;
   logic [2:0]   step;
   logic [1:0]   qcnt;
   logic [3:0]   bit_n;
   logic [31:0]  qdiv;
   logic         scl_r;
   logic         sda_oe_r;

   // ==========================================
   // Register decode
   wire qtick    = (qdiv == 32'(QUARTER_CYCLES - 1));
   wire ctrl_wr  = wr && (addr == sps_pkg::H_REG_CTRL) && !busy;
   wire start_wr = ctrl_wr && wdata[sps_pkg::H_CTRL_WR];
   wire start_rd = ctrl_wr && wdata[sps_pkg::H_CTRL_RD] && !wdata[sps_pkg::H_CTRL_WR];
   wire nack_clr = wr && (addr == sps_pkg::H_REG_STAT) && wdata[sps_pkg::H_STAT_NACK];
   wire rx_byte  = is_rd && step == 3'h5;
   wire [7:0] cur_byte = (step == 3'h1) ? {sps_pkg::DEV_ADDR, sps_pkg::DIR_WRITE}
                       : (step == 3'h2) ? ptr_r
                       : (step == 3'h4) ? {sps_pkg::DEV_ADDR, sps_pkg::DIR_READ} : wdata_r;
   wire [2:0] last_step = is_rd ? 3'h6 : 3'h4;
   wire [7:0] stat = {6'h00, nack, busy};
   wire [7:0] rd_mux = (addr == sps_pkg::H_REG_PTR)   ? ptr_r
                     : (addr == sps_pkg::H_REG_WDATA) ? wdata_r
                     : (addr == sps_pkg::H_REG_STAT)  ? stat
                     : (addr == sps_pkg::H_REG_RDATA) ? rdata_r : 8'h00;
   wire got_nack = (h_st == H_BYTE) && qtick && qcnt == 2'h2 && bit_n == 4'h8
                 && !rx_byte && link.sda;

   assign link.scl         = scl_r;
   assign link.host_sda_o  = 1'b0;
   assign link.host_sda_oe = sda_oe_r;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ptr_r   <= 8'h00;
         wdata_r <= 8'h00;
         rdata   <= 8'h00;
         nack    <= 1'b0;
      end
      else
      begin
         if (wr && addr == sps_pkg::H_REG_PTR && !busy)
            ptr_r <= wdata;
         if (wr && addr == sps_pkg::H_REG_WDATA && !busy)
            wdata_r <= wdata;
         rdata <= rd ? rd_mux : 8'h00;
         if (got_nack)
            nack <= 1'b1;
         else if (nack_clr)
            nack <= 1'b0;
      end
   end

   // ==========================================
   // Bit engine
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         h_st <= H_IDLE;
         busy <= 1'b0;
         is_rd <= 1'b0;
         step <= 3'h0;
         qcnt <= 2'h0;
         bit_n <= 4'h0;
         qdiv <= 32'h0;
         rxsh <= 8'h00;
         rdata_r <= 8'h00;
         scl_r <= 1'b1;
         sda_oe_r <= 1'b0;
      end
      else if (h_st == H_IDLE)
      begin
         qdiv <= 32'h0;
         qcnt <= 2'h0;
         if (start_wr || start_rd)
         begin
            busy  <= 1'b1;
            is_rd <= start_rd;
            step  <= 3'h0;
            bit_n <= 4'h0;
            h_st  <= H_START; // R12 R13
         end
      end
      else
      begin
         qdiv <= qtick ? 32'h0 : qdiv + 32'h1;
         if (qtick)
         begin
            qcnt <= qcnt + 2'h1;
            case (qcnt)
               2'h0:
               begin
                  scl_r    <= 1'b0;
                  sda_oe_r <= (h_st == H_STOP) || (h_st == H_BYTE && !rx_byte
                              && bit_n < 4'h8 && !cur_byte[3'(4'h7 - bit_n)]);
               end
               2'h1:
                  scl_r <= 1'b1;
               2'h2:
               begin
                  if (h_st == H_START)
                     sda_oe_r <= 1'b1;
                  if (h_st == H_STOP)
                     sda_oe_r <= 1'b0;
                  if (rx_byte && h_st == H_BYTE && bit_n < 4'h8)
                     rxsh <= {rxsh[6:0], link.sda};
                  if (got_nack)
                     step <= last_step - 3'h1;
               end
               default:
               begin
                  if (h_st == H_STOP)
                  begin
                     busy <= 1'b0;
                     h_st <= H_IDLE;
                     if (is_rd)
                        rdata_r <= rxsh;
                  end
                  else
                  begin
                     scl_r <= 1'b0;
                     if (h_st == H_BYTE && bit_n != 4'h8)
                        bit_n <= bit_n + 4'h1;
                     else
                     begin
                        bit_n <= 4'h0;
                        step  <= step + 3'h1;
                        h_st  <= kind_of(step + 3'h1, is_rd); // R14 R16
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/sps_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sps_asserts (
   // Clock and reset
   input wire logic              clk,
   input wire logic              reset_n,
   // Link, quarter of 4 clk
   input wire logic              scl,
   input wire logic              host_sda_o,
   input wire logic              host_sda_oe,
   input wire logic              dev_sda_o,
   input wire logic              dev_sda_oe,
   // Synthesizer
   input wire logic signed [7:0] sample,
   input wire logic              playing
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // =====
   // Link
   a_pins_low: assert property (!host_sda_o && !dev_sda_o)
      else $error("sda driven high");
   a_no_fight: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
      else $error("both ends drive sda");
   a_dev_hold: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device sda moved with scl high");
   a_dev_rise_low: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device took sda with scl high");
   a_scl_high_min: assert property ($rose(scl) |-> scl[*4])
      else $error("scl high too short");
   a_scl_low_min: assert property ($fell(scl) |-> !scl[*4])
      else $error("scl low too short");
   // =====
   // Output
   a_idle_silent: assert property (!playing && !$past(playing) |-> sample == 8'sh00)
      else $error("sample not zero while idle");
   a_end_silent: assert property ($fell(playing) |-> sample == 8'sh00)
      else $error("sample not zero at end of playback");
   a_peak_limit: assert property (sample != 8'sh80)
      else $error("sample beyond full scale");
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic              clk = 0;
   logic              reset_n = 0;
   logic [2:0]        addr = 0;
   logic [7:0]        wdata = 0;
   logic              wr = 0;
   logic              rd = 0;
   logic              rd_d = 0;
   logic              play_d = 0;
   logic [7:0]        rdata;
   logic signed [7:0] sample;
   logic              playing;
   logic [15:0]       note;
   logic [15:0]       rq[$];
   int                pq[$];
   int                mismatches = 0;
   int                num_checks = 0;
   int                dur = 0;
   int                pk = 0;
   sps_if link ();
   sps_host #(.QUARTER_CYCLES(4)) i_sps_host (.clk(clk), .reset_n(reset_n), .link(link),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   sps_device #(.TICK_CYCLES(4), .MS_CYCLES(50)) i_sps_device (.clk(clk),
      .reset_n(reset_n), .link(link), .sample(sample), .playing(playing));
   sps_asserts i_sps_asserts (.clk(clk), .reset_n(reset_n), .scl(link.scl),
      .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
      .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
      .sample(sample), .playing(playing));
   always #4 clk = ~clk;
   task automatic summarize();
      mismatches += rq.size() + pq.size();
      if (mismatches == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] a, input logic [31:0] e);
      num_checks++;
      if (a !== e)
      begin
         mismatches++;
         $display("Error at %0t: got %0h want %0h", $time, a, e);
      end
   endtask
   // =====
   // Result watcher
   always @(posedge clk)
   begin
      rd_d <= rd;
      play_d <= playing;
      if (rd_d)
      begin
         note = rq.pop_front();
         check(rdata & note[15:8], note[7:0]);
      end
      if (play_d === 1'b1 && playing === 1'b0 && pq.size() > 1)
      begin
         check(dur >= pq[0] && dur <= pq[0] + 99, 1);
         check(pk >= pq[1] - 1 && pk <= pq[1] + 1, 1);
         void'(pq.pop_front());
         void'(pq.pop_front());
      end
      dur <= (playing === 1'b1) ? dur + 1 : 0;
      pk <= (playing !== 1'b1) ? 0 : ((sample > pk) ? sample : pk);
   end
   // =====
   // Register port and link transfers
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                      input logic [7:0] m);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      if (!w)
         rq.push_back({m, d & m});
   endtask
   task automatic idle();
      for (int n = 0; n < 999; n++)
      begin
         bus(1'b0, 3'h3, 8'h00, 8'h02);
         #1;
         if (rdata[0] === 1'b0)
            return;
      end
      mismatches++;
   endtask
   task automatic put(input logic [7:0] p, input logic [7:0] d);
      bus(1'b1, 3'h0, p, 8'h00);
      bus(1'b1, 3'h1, d, 8'h00);
      bus(1'b1, 3'h2, 8'h01, 8'h00);
      idle();
   endtask
   task automatic get(input logic [7:0] p, input logic [7:0] e);
      bus(1'b1, 3'h0, p, 8'h00);
      bus(1'b1, 3'h2, 8'h02, 8'h00);
      idle();
      bus(1'b0, 3'h4, e, 8'hFF);
   endtask
   task automatic play(input logic [7:0] a, input logic [7:0] e, input logic [7:0] rep);
      int fr;
      int ms;
      fr = 8 << $urandom_range(1, 0);
      ms = (e[3:0] <= 8) ? 32 * e[3:0] : 256 * (e[3:0] - 7);
      put(8'hFF, 8'h01);
      put(8'h05, rep);
      put(8'h10, a);
      put(8'h11, fr[7:0]);
      put(8'h13, e);
      put(8'hFF, 8'h00);
      if (rep != 8'h00)
      begin
         pq.push_back(32768 / fr + a * ((ms * 50) / 255));
         pq.push_back(127 * a / 255);
      end
      put(8'h02, 8'h01);
   endtask
   initial
   begin
      logic [7:0] amp [4] = '{8'h00, 8'h55, 8'hFF, 8'h40};
      logic [7:0] env [4] = '{8'h00, 8'h00, 8'h01, 8'h19};
      logic [7:0] hp [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h12};
      logic [7:0] hd [5] = '{8'h80, 8'h10, 8'h00, 8'h13, 8'h08};
      void'($urandom(32'h38d7));
      amp[1] = 8'($urandom_range(255, 1));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, 3'h5, 8'h00, 8'hFF);
      get(8'h02, 8'h00);
      get(8'h0A, 8'h00);
      put(8'h03, 8'h01);
      get(8'h03, 8'h01);
      put(8'hFF, 8'h01);
      for (int i = 0; i < 5; i++)
         put(hp[i], hd[i]);
      get(8'h02, 8'h10);
      put(8'hFF, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         play(amp[i], env[i], 8'h01);
         for (int n = 0; n < 20000 && playing !== 1'b0; n++)
            @(posedge clk);
         get(8'h02, 8'h00);
      end
      // Direct playback of the last parameter bytes
      put(8'hFF, 8'h01);
      put(8'h01, 8'h00);
      put(8'hFF, 8'h00);
      pq.push_back(16);
      pq.push_back(64);
      put(8'h02, 8'h01);
      repeat (200) @(posedge clk);
      get(8'h02, 8'h00);
      put(8'hFF, 8'h01);
      put(8'h01, 8'h80);
      play(8'h30, 8'h00, 8'h00);
      repeat (5000) @(posedge clk);
      get(8'h02, 8'h01);
      put(8'h02, 8'h00);
      get(8'h02, 8'h00);
      repeat (2) @(posedge clk);
      summarize();
   end
   initial
   begin
      #800000;
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
